// ==== verilog/dnr_consts.svh ====
// Purpose: constants for the dual-core nmi and reset control block
// Assumes: 10 MHz clk, synchronous active-high reset
// Notes: counts are clock cycles unless the name says otherwise
`ifndef DNR_CONSTS_SVH
`define DNR_CONSTS_SVH

// ************************************************************
// nmi source layout
// ************************************************************
`define DNR_NMI_SRCS 7
`define DNR_M_CTRL_WD 0
`define DNR_M_VFETCH 1
`define DNR_M_OSC 2
`define DNR_M_ABUS 3
`define DNR_M_EXT 4
`define DNR_M_MBIST 5
`define DNR_M_CBIST 6
`define DNR_C_OSC 0
`define DNR_C_ABUS 1
`define DNR_C_RAM 2
`define DNR_C_FLASH 3
`define DNR_C_VFETCH 4
`define DNR_C_CBIST 5
`define DNR_C_MBIST 6

// ************************************************************
// timing and peripheral count
// ************************************************************
`define DNR_NMI_WD_LIMIT 16'h0FFF
`define DNR_PIN_PULSE 8
`define DNR_PERIPHS 8

// ************************************************************
// reset cause bits
// ************************************************************
`define DNR_CAUSE_EXT 0
`define DNR_CAUSE_POR 1
`define DNR_CAUSE_WD0 2
`define DNR_CAUSE_WD1 3
`define DNR_CAUSE_SW 4

`endif

// ==== verilog/dnr_pkg.sv ====
// Purpose: types for the dual-core nmi and reset control block
// Assumes: constants come from dnr_consts.svh
// Notes: none
`include "dnr_consts.svh"
package dnr_pkg;
    typedef logic [`DNR_NMI_SRCS-1:0] dnr_src_t;

    // software access to one nmi unit
    typedef struct packed {
        dnr_src_t clear;
        dnr_src_t force_set;
        logic wd_disable;
    } dnr_nmi_sw_t;

    // reset configuration written by the master cpu
    typedef struct packed {
        logic selective_control_reset_bit;
        logic analog_bus_reset;
        logic sw_to_control_en;
        logic dbg_to_control_en;
    } dnr_rst_cfg_t;

    typedef enum logic [2:0] {
        DNR_WD_IDLE = 3'b001,
        DNR_WD_RUN = 3'b010,
        DNR_WD_FIRED = 3'b100
    } dnr_wd_state_t;
endpackage

// ==== verilog/dnr_nmi_unit.sv ====
// Purpose: one nmi unit: sticky source flags, nmi output and nmi watchdog
// Assumes: sources are synchronous to clk
// Notes: the watchdog reset output stays asserted until srst
`timescale 1ns/10ps
`include "dnr_consts.svh"
module dnr_nmi_unit #(
    parameter logic [15:0] WD_LIMIT = `DNR_NMI_WD_LIMIT
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // sources and software access
    input wire dnr_pkg::dnr_src_t src,
    input wire dnr_pkg::dnr_src_t src_en,
    input wire dnr_pkg::dnr_nmi_sw_t sw,
    // results
    output dnr_pkg::dnr_src_t flags,
    output logic nonmaskable_irq,
    output logic watchdog_event,
    output logic watchdog_reset
);
    dnr_pkg::dnr_src_t flags_reg;
    dnr_pkg::dnr_src_t flags_next;
    dnr_pkg::dnr_wd_state_t st_reg;
    dnr_pkg::dnr_wd_state_t st_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    // ************************************************************
    // flags: set beats clear so no event is lost
    // ************************************************************
    always_comb
    begin
        flags_next = (flags_reg & ~sw.clear) | (src & src_en)
            | sw.force_set;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    assign flags = flags_reg;
    assign nonmaskable_irq = |flags_reg;
    assign watchdog_event = (|flags_reg) && (st_reg == dnr_pkg::DNR_WD_IDLE);

    // ************************************************************
    // nmi watchdog: armed by the nmi, stopped by software
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            dnr_pkg::DNR_WD_IDLE:
            begin
                cnt_next = '0;
                if (|flags_reg && !sw.wd_disable)
                    st_next = dnr_pkg::DNR_WD_RUN;
            end
            dnr_pkg::DNR_WD_RUN:
            begin
                if (sw.wd_disable)
                    st_next = dnr_pkg::DNR_WD_IDLE;
                else if (cnt_reg == WD_LIMIT)
                    st_next = dnr_pkg::DNR_WD_FIRED;
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
            dnr_pkg::DNR_WD_FIRED:
                st_next = dnr_pkg::DNR_WD_FIRED;
            default:
                st_next = dnr_pkg::DNR_WD_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= dnr_pkg::DNR_WD_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    assign watchdog_reset = (st_reg == dnr_pkg::DNR_WD_FIRED);

    a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
        (|flags_reg) && !(|sw.clear) |=> (|flags_reg))
        else $error("flag dropped without clear");
    a_wd_fires: assert property (@(posedge clk) disable iff (srst)
        st_reg == dnr_pkg::DNR_WD_RUN && cnt_reg == WD_LIMIT
        && !sw.wd_disable |=> watchdog_reset)
        else $error("nmi watchdog did not fire at limit");
    a_force_irq: assert property (@(posedge clk) disable iff (srst)
        (|sw.force_set) |=> nonmaskable_irq)
        else $error("force did not raise nmi");
endmodule

// ==== verilog/dnr_top.sv ====
// Purpose: nmi aggregation and reset distribution for a dual-cpu device
// Assumes: all inputs synchronous to clk; srst models power-on reset
// Notes: pins are split into in, out and active-low output enable
`timescale 1ns/10ps
`include "dnr_consts.svh"
module dnr_top #(
    parameter int PERIPHS = `DNR_PERIPHS,
    parameter logic [15:0] WD_LIMIT = `DNR_NMI_WD_LIMIT
) (
    // clock and power-on
    input wire logic clk,
    input wire logic srst,
    input wire logic analog_por,
    // error sources
    input wire logic vector_fetch_error,
    input wire logic oscillator_missing,
    input wire logic analog_bus_error,
    input wire logic external_emergency_input,
    input wire logic master_selftest_error,
    input wire logic control_selftest_error,
    input wire logic ram_uncorrectable_error,
    input wire logic flash_uncorrectable_error,
    // nmi software access
    input wire dnr_pkg::dnr_src_t master_nmi_src_en,
    input wire dnr_pkg::dnr_nmi_sw_t master_nmi_sw,
    input wire dnr_pkg::dnr_nmi_sw_t control_nmi_sw,
    output dnr_pkg::dnr_src_t master_nmi_flags,
    output dnr_pkg::dnr_src_t control_nmi_flags,
    // nmi outputs
    output logic master_nonmaskable_irq,
    output logic master_nmi_watchdog_event,
    output logic master_nmi_watchdog_reset,
    output logic control_nonmaskable_irq,
    output logic control_nmi_watchdog_event,
    output logic control_nmi_watchdog_reset,
    // watchdogs and reset requests
    input wire logic master_wd0_timeout,
    input wire logic master_wd1_timeout,
    input wire logic software_reset_request,
    input wire logic debugger_reset_request,
    input wire dnr_pkg::dnr_rst_cfg_t control_reset_config_reg,
    input wire logic [PERIPHS-1:0] peripheral_reset_control_reg,
    input wire logic [PERIPHS-1:0] device_config_register,
    // pins
    input wire logic main_reset_pin_in,
    output logic main_reset_pin_out,
    output logic main_reset_pin_oe_n,
    input wire logic analog_reset_pin_in,
    output logic analog_reset_pin_out,
    output logic analog_reset_pin_oe_n,
    // reset targets and status
    output logic master_system_reset,
    output logic master_cpu_reset,
    output logic [PERIPHS-1:0] master_periph_reset,
    output logic control_reset_input,
    output logic control_system_reset,
    output logic analog_reset,
    output logic analog_bus_reset_out,
    output logic control_in_reset_bit,
    output logic [4:0] master_reset_cause_reg,
    output logic [1:0] device_status_config_reg
);
    dnr_pkg::dnr_src_t msrc;
    dnr_pkg::dnr_src_t csrc;
    logic master_watchdog_timeout_reset;
    logic main_pin_low;
    logic [3:0] pulse_reg;
    logic [3:0] pulse_next;
    logic [4:0] cause_reg;
    logic [4:0] cause_next;
    logic sysrst_reg;
    logic sysrst_next;
    logic ctlrst_reg;
    logic ctlrst_next;
    logic [PERIPHS-1:0] per_reg;
    logic [PERIPHS-1:0] per_next;

    // ************************************************************
    // nmi source wiring
    // ************************************************************
    always_comb
    begin
        msrc = '0;
        msrc[`DNR_M_CTRL_WD] = control_nmi_watchdog_reset;
        msrc[`DNR_M_VFETCH] = vector_fetch_error;
        msrc[`DNR_M_OSC] = oscillator_missing;
        msrc[`DNR_M_ABUS] = analog_bus_error;
        msrc[`DNR_M_EXT] = external_emergency_input;
        msrc[`DNR_M_MBIST] = master_selftest_error;
        msrc[`DNR_M_CBIST] = control_selftest_error;
        csrc = '0;
        csrc[`DNR_C_OSC] = oscillator_missing;
        csrc[`DNR_C_ABUS] = analog_bus_error;
        csrc[`DNR_C_RAM] = ram_uncorrectable_error;
        csrc[`DNR_C_FLASH] = flash_uncorrectable_error;
        csrc[`DNR_C_VFETCH] = vector_fetch_error;
        csrc[`DNR_C_CBIST] = control_selftest_error;
        csrc[`DNR_C_MBIST] = master_selftest_error;
    end

    // master unit: only enabled sources count
    dnr_nmi_unit #(.WD_LIMIT(WD_LIMIT)) u_master_nmi (
        .clk(clk),
        .srst(srst),
        .src(msrc),
        .src_en(master_nmi_src_en),
        .sw(master_nmi_sw),
        .flags(master_nmi_flags),
        .nonmaskable_irq(master_nonmaskable_irq),
        .watchdog_event(master_nmi_watchdog_event),
        .watchdog_reset(master_nmi_watchdog_reset)
    );

    // control unit: every source is critical
    dnr_nmi_unit #(.WD_LIMIT(WD_LIMIT)) u_control_nmi (
        .clk(clk),
        .srst(srst),
        .src(csrc),
        .src_en('1),
        .sw(control_nmi_sw),
        .flags(control_nmi_flags),
        .nonmaskable_irq(control_nonmaskable_irq),
        .watchdog_event(control_nmi_watchdog_event),
        .watchdog_reset(control_nmi_watchdog_reset)
    );

    // ************************************************************
    // main pin driver and reset combining
    // ************************************************************
    assign master_watchdog_timeout_reset = master_wd0_timeout
        | master_wd1_timeout | master_nmi_watchdog_reset;
    assign main_pin_low = !main_reset_pin_in;

    // pulse stretch keeps the pin low long enough to be seen off chip
    always_comb
    begin
        pulse_next = pulse_reg;
        if (master_watchdog_timeout_reset)
            pulse_next = 4'(`DNR_PIN_PULSE);
        else if (pulse_reg != 4'h0)
            pulse_next = pulse_reg - 4'h1;
        sysrst_next = main_pin_low | master_watchdog_timeout_reset
            | software_reset_request | debugger_reset_request;
        ctlrst_next = main_pin_low | control_nmi_watchdog_reset
            | (software_reset_request
               & control_reset_config_reg.sw_to_control_en)
            | (debugger_reset_request
               & control_reset_config_reg.dbg_to_control_en)
            | control_reset_config_reg.selective_control_reset_bit;
        per_next = peripheral_reset_control_reg
            & device_config_register;
        cause_next = cause_reg;
        if ((main_pin_low && pulse_reg == 4'h0) || software_reset_request
            || master_wd0_timeout || master_wd1_timeout)
        begin
            cause_next = '0; // latest reset replaces the record
            cause_next[`DNR_CAUSE_EXT] = main_pin_low
                && pulse_reg == 4'h0;
            cause_next[`DNR_CAUSE_WD0] = master_wd0_timeout;
            cause_next[`DNR_CAUSE_WD1] = master_wd1_timeout;
            cause_next[`DNR_CAUSE_SW] = software_reset_request;
        end
    end

    // srst is the power-on model, so cause restarts as power-on
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pulse_reg <= 4'h0;
            cause_reg <= 5'h01 << `DNR_CAUSE_POR; // power-on
            sysrst_reg <= 1'b1;
            ctlrst_reg <= 1'b1;
            per_reg <= '0;
        end
        else
        begin
            pulse_reg <= pulse_next;
            cause_reg <= cause_next;
            sysrst_reg <= sysrst_next;
            ctlrst_reg <= ctlrst_next;
            per_reg <= per_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign main_reset_pin_out = 1'b0;
    assign main_reset_pin_oe_n = !(srst || pulse_reg != 4'h0);
    assign analog_reset_pin_out = 1'b0;
    assign analog_reset_pin_oe_n = !analog_por;
    assign master_system_reset = sysrst_reg;
    assign master_cpu_reset = srst | sysrst_reg;
    assign master_periph_reset = per_reg | {PERIPHS{sysrst_reg}};
    assign control_reset_input = srst | ctlrst_reg;
    assign control_system_reset = control_reset_input;
    assign analog_reset = !analog_reset_pin_in | analog_por
        | (software_reset_request
           & control_reset_config_reg.sw_to_control_en)
        | (debugger_reset_request
           & control_reset_config_reg.dbg_to_control_en);
    assign analog_bus_reset_out =
        control_reset_config_reg.analog_bus_reset;
    assign control_in_reset_bit = control_system_reset;
    assign master_reset_cause_reg = cause_reg;
    assign device_status_config_reg =
        {main_reset_pin_in, control_reset_config_reg.analog_bus_reset};

    a_wd_drives_pin: assert property (@(posedge clk) disable iff (srst)
        master_watchdog_timeout_reset |=> !main_reset_pin_oe_n)
        else $error("watchdog timeout did not drive pin");
    a_pin_sysrst: assert property (@(posedge clk) disable iff (srst)
        !main_reset_pin_in |=> master_system_reset && control_reset_input)
        else $error("pin low did not reset subsystems");
    a_sel_ctl: assert property (@(posedge clk) disable iff (srst)
        control_reset_config_reg.selective_control_reset_bit
        |=> control_in_reset_bit)
        else $error("selective reset not shown");
    a_periph_gate: assert property (@(posedge clk) disable iff (srst)
        !device_config_register[0] && !sysrst_next
        |=> !master_periph_reset[0])
        else $error("disabled peripheral reset");
    a_wd0_cause: assert property (@(posedge clk) disable iff (srst)
        master_wd0_timeout |=> master_reset_cause_reg[`DNR_CAUSE_WD0])
        else $error("wd0 cause not recorded");
endmodule

// ==== tb/dnr_pin_model.sv ====
// Purpose: far-side model of the two reset pins and their board drivers
// Assumes: both pins carry pull-ups; bench drivers change on falling edge
// Notes: the power-up hold happens once, counted from time zero
`timescale 1ns/10ps
module dnr_pin_model (
    // clock
    input wire logic clk,
    // board-side drivers
    input wire logic ext_low,
    input wire logic ana_low,
    // device side of the pins
    input wire logic main_oe_n,
    input wire logic main_out,
    input wire logic ana_oe_n,
    input wire logic ana_out,
    // resolved pin levels
    output logic main_lvl,
    output logic ana_lvl
);
    // ************************************************************
    // power-up hold and wired pins
    // ************************************************************
    logic [3:0] hold_cnt_reg = 4'h0;

    // supervisor keeps the main pin low for eight clocks once clk runs
    always_ff @(posedge clk)
    begin
        if (hold_cnt_reg != 4'h8)
            hold_cnt_reg <= hold_cnt_reg + 4'h1;
    end

    // pull-up: any party driving low wins, released pin reads high
    assign main_lvl = ~((~main_oe_n & ~main_out) | ext_low |
        (hold_cnt_reg != 4'h8));
    assign ana_lvl = ~((~ana_oe_n & ~ana_out) | ana_low);
endmodule

// ==== tb/dnr_tb_top.sv ====
// Purpose: self-checking bench for the nmi and reset control block
// Assumes: WD_LIMIT shortened to 8; inputs change on the falling edge
// Notes: watchdog reset outputs stand until srst, so all tests but t_src and t_ana reset first
`timescale 1ns/10ps
`include "dnr_consts.svh"
module dual_core_nmi_and_reset_control_tb_top;
    // ************************************************************
    // signals and instances
    // ************************************************************
    localparam logic [15:0] WDL = 16'h0008;
    localparam int MI[6] = '{`DNR_M_VFETCH, `DNR_M_OSC, `DNR_M_ABUS,
        `DNR_M_EXT, `DNR_M_MBIST, `DNR_M_CBIST};
    localparam int CI[8] = '{`DNR_C_VFETCH, `DNR_C_OSC, `DNR_C_ABUS, 0,
        `DNR_C_MBIST, `DNR_C_CBIST, `DNR_C_RAM, `DNR_C_FLASH};
    int fails = 0;
    int checked = 0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic analog_por = 1'b0;
    logic [7:0] errs = 8'h00;
    dnr_pkg::dnr_src_t master_nmi_src_en = 7'h00;
    dnr_pkg::dnr_nmi_sw_t master_nmi_sw = '0;
    dnr_pkg::dnr_nmi_sw_t control_nmi_sw = '0;
    dnr_pkg::dnr_rst_cfg_t control_reset_config_reg = '0;
    logic master_wd0_timeout = 1'b0;
    logic master_wd1_timeout = 1'b0;
    logic software_reset_request = 1'b0;
    logic debugger_reset_request = 1'b0;
    logic [7:0] peripheral_reset_control_reg = 8'h00;
    logic [7:0] device_config_register = 8'h00;
    logic ext_low = 1'b0;
    logic ana_low = 1'b0;
    logic main_lvl, ana_lvl;
    dnr_pkg::dnr_src_t master_nmi_flags, control_nmi_flags;
    logic master_nonmaskable_irq, master_nmi_watchdog_event;
    logic master_nmi_watchdog_reset, control_nonmaskable_irq;
    logic control_nmi_watchdog_event, control_nmi_watchdog_reset;
    logic main_reset_pin_out, main_reset_pin_oe_n;
    logic analog_reset_pin_out, analog_reset_pin_oe_n;
    logic master_system_reset, master_cpu_reset, control_reset_input;
    logic control_system_reset, analog_reset, analog_bus_reset_out;
    logic control_in_reset_bit;
    logic [7:0] master_periph_reset;
    logic [4:0] master_reset_cause_reg;
    logic [1:0] device_status_config_reg;

    dnr_top #(.PERIPHS(8), .WD_LIMIT(WDL)) dut (
        .clk, .srst, .analog_por, .vector_fetch_error(errs[0]),
        .oscillator_missing(errs[1]), .analog_bus_error(errs[2]),
        .external_emergency_input(errs[3]),
        .master_selftest_error(errs[4]), .control_selftest_error(errs[5]),
        .ram_uncorrectable_error(errs[6]),
        .flash_uncorrectable_error(errs[7]),
        .master_nmi_src_en, .master_nmi_sw, .control_nmi_sw,
        .master_nmi_flags, .control_nmi_flags, .master_nonmaskable_irq,
        .master_nmi_watchdog_event, .master_nmi_watchdog_reset,
        .control_nonmaskable_irq, .control_nmi_watchdog_event,
        .control_nmi_watchdog_reset, .master_wd0_timeout,
        .master_wd1_timeout, .software_reset_request,
        .debugger_reset_request, .control_reset_config_reg,
        .peripheral_reset_control_reg, .device_config_register,
        .main_reset_pin_in(main_lvl), .main_reset_pin_out,
        .main_reset_pin_oe_n, .analog_reset_pin_in(ana_lvl),
        .analog_reset_pin_out, .analog_reset_pin_oe_n,
        .master_system_reset, .master_cpu_reset, .master_periph_reset,
        .control_reset_input, .control_system_reset, .analog_reset,
        .analog_bus_reset_out, .control_in_reset_bit,
        .master_reset_cause_reg, .device_status_config_reg
    );

    dnr_pin_model u_pins (
        .clk, .ext_low, .ana_low, .main_oe_n(main_reset_pin_oe_n),
        .main_out(main_reset_pin_out), .ana_oe_n(analog_reset_pin_oe_n),
        .ana_out(analog_reset_pin_out), .main_lvl, .ana_lvl
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [7:0] got,
        input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // sticky watchdog resets need a full reset between tests
    task automatic do_rst();
        srst = 1'b1;
        cyc(12);
        srst = 1'b0;
        cyc(12);
    endtask

    task automatic clr();
        master_nmi_sw.clear = 7'h7F;
        control_nmi_sw.clear = 7'h7F;
        cyc(1);
        master_nmi_sw.clear = 7'h00;
        control_nmi_sw.clear = 7'h00;
        cyc(1);
    endtask

    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // one-cycle source pulses, checked after they drop, both enables
    task automatic t_src();
        logic [7:0] em, ec;
        master_nmi_sw.wd_disable = 1'b1;
        control_nmi_sw.wd_disable = 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            master_nmi_src_en = p ? 7'h7F : 7'h00;
            for (int k = 0; k < 8; k++)
            begin
                errs = 8'h01 << k;
                cyc(1);
                errs = 8'h00;
                cyc(1);
                em = (p && k < 6) ? 8'h01 << MI[k] : 8'h00;
                ec = (k == 3) ? 8'h00 : 8'h01 << CI[k];
                chk("mflags", master_nmi_flags, em);
                chk("cflags", control_nmi_flags, ec);
                chk("cirq", control_nonmaskable_irq, ec != 0);
                clr();
                chk("mclr", master_nmi_flags, 8'h00);
                chk("cclr", control_nmi_flags, 8'h00);
            end
        end
        master_nmi_sw.wd_disable = 1'b0;
        control_nmi_sw.wd_disable = 1'b0;
        $display("test sources done");
    endtask

    // forced flag left unserviced until the nmi watchdog fires
    task automatic t_mwd();
        int n;
        do_rst();
        master_nmi_sw.force_set = 7'h04;
        cyc(1);
        master_nmi_sw.force_set = 7'h00;
        chk("flag", master_nmi_flags, 8'h04);
        chk("irq", master_nonmaskable_irq, 8'h01);
        chk("event", master_nmi_watchdog_event, 8'h01);
        cyc(6);
        chk("early", master_nmi_watchdog_reset, 8'h00);
        n = 0;
        while (master_nmi_watchdog_reset !== 1'b1 && n < 30)
        begin
            cyc(1);
            n++;
        end
        chk("wdrst", master_nmi_watchdog_reset, 8'h01);
        cyc(2);
        chk("sysrst", master_system_reset, 8'h01);
        chk("pin", main_reset_pin_oe_n, 8'h00);
        chk("plvl", main_lvl, 8'h00);
        chk("sticky", master_nmi_flags, 8'h04);
        $display("test master watchdog done");
    endtask

    // serviced nmi: running watchdog stopped, flag cleared
    task automatic t_wddis();
        do_rst();
        master_nmi_sw.force_set = 7'h40;
        cyc(1);
        master_nmi_sw.force_set = 7'h00;
        cyc(3);
        master_nmi_sw.wd_disable = 1'b1;
        cyc(30);
        chk("held", master_nmi_watchdog_reset, 8'h00);
        clr();
        chk("clr", master_nmi_flags, 8'h00);
        chk("irq0", master_nonmaskable_irq, 8'h00);
        master_nmi_sw.wd_disable = 1'b0;
        $display("test watchdog disable done");
    endtask

    // control watchdog timeout resets control and feeds the master unit
    task automatic t_cwd();
        int n;
        do_rst();
        master_nmi_src_en = 7'h01;
        control_nmi_sw.force_set = 7'h08;
        cyc(1);
        control_nmi_sw.force_set = 7'h00;
        chk("cevt", control_nmi_watchdog_event, 8'h01);
        n = 0;
        while (control_nmi_watchdog_reset !== 1'b1 && n < 30)
        begin
            cyc(1);
            n++;
        end
        chk("cwd", control_nmi_watchdog_reset, 8'h01);
        cyc(2);
        chk("mflag0", master_nmi_flags[0], 8'h01);
        chk("cin", control_reset_input, 8'h01);
        chk("csys", control_system_reset, 8'h01);
        chk("msys", master_system_reset, 8'h00);
        $display("test control watchdog done");
    endtask

    // wd0, wd1, then software and debugger with path gate off and on
    task automatic t_req();
        logic [4:0] cm;
        for (int c = 0; c < 6; c++)
        begin
            do_rst();
            control_reset_config_reg.sw_to_control_en = c[0];
            control_reset_config_reg.dbg_to_control_en = c[0];
            master_wd0_timeout = (c == 0);
            master_wd1_timeout = (c == 1);
            software_reset_request = (c == 2 || c == 3);
            debugger_reset_request = (c > 3);
            cyc(1);
            cm = (c == 0) ? 5'h01 << `DNR_CAUSE_WD0 :
                (c == 1) ? 5'h01 << `DNR_CAUSE_WD1 :
                (c < 4) ? 5'h01 << `DNR_CAUSE_SW : 5'h00;
            chk("msys", master_system_reset, 8'h01);
            chk("mcpu", master_cpu_reset, 8'h01);
            chk("mper", master_periph_reset, 8'hFF);
            chk("pin", main_reset_pin_oe_n, c < 2 ? 8'h00 : 8'h01);
            chk("cause", master_reset_cause_reg & cm, cm);
            chk("ana", analog_reset, c > 1 && c[0]);
            if (c > 1)
                chk("cin", control_reset_input, c[0]);
            master_wd0_timeout = 1'b0;
            master_wd1_timeout = 1'b0;
            software_reset_request = 1'b0;
            debugger_reset_request = 1'b0;
            cyc(2);
            chk("keep", master_reset_cause_reg & cm, cm);
        end
        control_reset_config_reg = '0;
        $display("test reset requests done");
    endtask

    // external low pulse on the main pin, then config and status bits
    task automatic t_pin();
        do_rst();
        ext_low = 1'b1;
        cyc(2);
        chk("msys", master_system_reset, 8'h01);
        chk("cin", control_reset_input, 8'h01);
        chk("lvl0", device_status_config_reg[1], 8'h00);
        ext_low = 1'b0;
        cyc(2);
        chk("ext", master_reset_cause_reg[`DNR_CAUSE_EXT], 8'h01);
        chk("rel", master_system_reset, 8'h00);
        chk("lvl1", device_status_config_reg[1], 8'h01);
        control_reset_config_reg.analog_bus_reset = 1'b1;
        cyc(2);
        chk("abr", analog_bus_reset_out, 8'h01);
        chk("abst", device_status_config_reg[0], 8'h01);
        control_reset_config_reg.analog_bus_reset = 1'b0;
        control_reset_config_reg.selective_control_reset_bit = 1'b1;
        cyc(2);
        chk("sel", control_reset_input, 8'h01);
        chk("sts", control_in_reset_bit, 8'h01);
        chk("msel", master_system_reset, 8'h00);
        control_reset_config_reg.selective_control_reset_bit = 1'b0;
        cyc(2);
        chk("sts0", control_in_reset_bit, 8'h00);
        $display("test pin and config done");
    endtask

    // analog power-on, analog pin pulse, gated peripheral resets
    task automatic t_ana();
        analog_por = 1'b1;
        cyc(2);
        chk("aoe", analog_reset_pin_oe_n, 8'h00);
        chk("ares", analog_reset, 8'h01);
        analog_por = 1'b0;
        cyc(12);
        chk("aoff", analog_reset, 8'h00);
        ana_low = 1'b1;
        cyc(1);
        chk("apin", analog_reset, 8'h01);
        ana_low = 1'b0;
        peripheral_reset_control_reg = 8'hA5;
        device_config_register = 8'h0F;
        cyc(2);
        chk("per", master_periph_reset, 8'h05);
        device_config_register = 8'hF0;
        cyc(2);
        chk("per2", master_periph_reset, 8'hA0);
        peripheral_reset_control_reg = 8'h00;
        $display("test analog and peripherals done");
    endtask

    // ************************************************************
    // main sequence and hang guard
    // ************************************************************
    initial
    begin
        cyc(11);
        chk("por_pin", main_reset_pin_oe_n, 8'h00);
        chk("por_cpu", master_cpu_reset, 8'h01);
        chk("por_cause", master_reset_cause_reg,
            8'h01 << `DNR_CAUSE_POR);
        chk("por_flag", master_nmi_flags, 8'h00);
        cyc(1);
        srst = 1'b0;
        cyc(12);
        $display("test power-on done");
        t_src();
        t_mwd();
        t_wddis();
        t_cwd();
        t_req();
        t_pin();
        t_ana();
        test_done();
    end

    // over twenty times the expected run, in case a wait hangs
    initial
    begin
        #1000000;
        fails++;
        test_done();
    end
endmodule
